// file: verilog/cpuibx_consts.vh
// constants for the halt, increment, return and branch execution core
`ifndef CPUIBX_CONSTS_VH
`define CPUIBX_CONSTS_VH
// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define CPUIBX_OP_IDLE 8'h6F
`define CPUIBX_OP_INC_R 8'h20
`define CPUIBX_OP_INC_IR 8'h21
`define CPUIBX_OP_WORD_ADD_ONE_OP_RR 8'hA0
`define CPUIBX_OP_WORD_ADD_ONE_OP_IR 8'hA1
`define CPUIBX_OP_SERVICE_RETURN_OP 8'hBF
`define CPUIBX_OP_JP_IRR 8'h30
`define CPUIBX_NIB_INC 4'hE
`define CPUIBX_NIB_JP 4'hD
`define CPUIBX_NIB_JR 4'hB
// ----------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------
`define CPUIBX_CYC_IDLE 4'h4
`define CPUIBX_CYC_INC 4'h4
`define CPUIBX_CYC_WORD_ADD_ONE_OP 4'h8
`define CPUIBX_CYC_SERVICE_RETURN_OP 4'hA
`define CPUIBX_CYC_SERVICE_RETURN_OP_FAST 4'h6
`define CPUIBX_CYC_JP 4'h8
`define CPUIBX_CYC_JR 4'h6
`define CPUIBX_CYC_OTHER 4'h4
// ----------------------------------------------------------------
// register space
// ----------------------------------------------------------------
`define CPUIBX_ADDR_FLAGS 8'hD5
`define CPUIBX_ADDR_SP 8'hD9
`define CPUIBX_ADDR_IP_HI 8'hDA
`define CPUIBX_ADDR_IP_LO 8'hDB
`define CPUIBX_ADDR_SYM 8'hDE
`define CPUIBX_WREG_BASE 4'hC
`define CPUIBX_RST_FLAGS 8'h00
`define CPUIBX_RST_SYM 8'h00
`define CPUIBX_RST_SP 8'hC0
`define CPUIBX_RST_IP 16'h0000
`define CPUIBX_RST_PC 16'h0000
// ----------------------------------------------------------------
// flag bit positions
// ----------------------------------------------------------------
`define CPUIBX_FL_C 7
`define CPUIBX_FL_Z 6
`define CPUIBX_FL_S 5
`define CPUIBX_FL_V 4
`define CPUIBX_FL_FIS 1
`define CPUIBX_SYM_GIE 0
`endif

// file: verilog/cpuibx_core.v
// execution core for halt, increment, interrupt return and branch instructions
// Overview of operation
// - halt opcode 6F, one byte, 4 cycles, stops core, flags kept
// - halted core resumes on interrupt request or reset
// - byte increment forms rE, 20, 21; one or two bytes; 4 cycles
// - increments set zero, sign, overflow from result; other flags kept
// - word increment A0/A1 on even pair, two bytes, 8 cycles
// - normal return BF pops flags, then program counter; 10 cycles
// - every interrupt return sets global interrupt enable
// - stack return only when fast-service bit of flags is zero
// - fast return swaps pc and pointer, restores flags, clears bit, 6 cycles
// - fast entry swaps pc with pointer, return address kept there
// - absolute branch ccD, three bytes, 8 cycles, loads address if true
// - indirect branch 30, two bytes, 8 cycles, loads pair contents
// - relative branch ccB, two bytes, 6 cycles, adds offset if true
// - offset signed byte added to address after the instruction
// - halt and branches leave every flag unchanged
// - mode bit zero gates servicing; requests are not latched meanwhile
`include "cpuibx_consts.vh"
module cpuibx_core (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // program memory
  output wire [15:0] prog_addr,
  input wire [7:0] prog_data,
  // interrupt side
  input wire irq_req,
  input wire irq_fast,
  input wire [15:0] irq_vector,
  output reg irq_ack,
  // status
  output reg cpu_idle,
  output reg [15:0] pc_value
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_FETCH = 4'b0001;
  localparam ST_EXEC = 4'b0010;
  localparam ST_HALT = 4'b0100;
  localparam ST_INT = 4'b1000;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [7:0] mem [0:255];
  reg [3:0] state_reg;
  reg [15:0] pc_reg;
  reg [15:0] ip_reg;
  reg [7:0] sp_reg;
  reg [7:0] flags_reg;
  reg [7:0] flags_save_reg;
  reg [7:0] sym_reg;
  reg [7:0] op_reg;
  reg [7:0] b2_reg;
  reg [7:0] b3_reg;
  reg [1:0] idx_reg;
  reg [3:0] cyc_reg;
  reg [3:0] step_reg;
  reg [7:0] ea_reg;
  reg [15:0] word_res_reg;
  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function [1:0] op_len;
    input [7:0] op;
    begin
      if (op[3:0] == `CPUIBX_NIB_JP) begin
        op_len = 2'd3;
      end else if (op[3:0] == `CPUIBX_NIB_JR || op == `CPUIBX_OP_INC_R ||
                   op == `CPUIBX_OP_INC_IR || op == `CPUIBX_OP_WORD_ADD_ONE_OP_RR ||
                   op == `CPUIBX_OP_WORD_ADD_ONE_OP_IR || op == `CPUIBX_OP_JP_IRR) begin
        op_len = 2'd2;
      end else begin
        op_len = 2'd1;
      end
    end
  endfunction
  function [3:0] op_cycles;
    input [7:0] op;
    input fast;
    begin
      if (op == `CPUIBX_OP_IDLE) begin
        op_cycles = `CPUIBX_CYC_IDLE;
      end else if (op == `CPUIBX_OP_SERVICE_RETURN_OP) begin
        op_cycles = fast ? `CPUIBX_CYC_SERVICE_RETURN_OP_FAST : `CPUIBX_CYC_SERVICE_RETURN_OP;
      end else if (op == `CPUIBX_OP_WORD_ADD_ONE_OP_RR || op == `CPUIBX_OP_WORD_ADD_ONE_OP_IR) begin
        op_cycles = `CPUIBX_CYC_WORD_ADD_ONE_OP;
      end else if (op[3:0] == `CPUIBX_NIB_JP || op == `CPUIBX_OP_JP_IRR) begin
        op_cycles = `CPUIBX_CYC_JP;
      end else if (op[3:0] == `CPUIBX_NIB_JR) begin
        op_cycles = `CPUIBX_CYC_JR;
      end else if (op[3:0] == `CPUIBX_NIB_INC || op == `CPUIBX_OP_INC_R ||
                   op == `CPUIBX_OP_INC_IR) begin
        op_cycles = `CPUIBX_CYC_INC;
      end else begin
        op_cycles = `CPUIBX_CYC_OTHER;
      end
    end
  endfunction
  // standard condition table, code 8 always true
  function cond_true;
    input [3:0] cc;
    input [7:0] f;
    reg c, z, s, v;
    begin
      c = f[`CPUIBX_FL_C];
      z = f[`CPUIBX_FL_Z];
      s = f[`CPUIBX_FL_S];
      v = f[`CPUIBX_FL_V];
      case (cc[2:0])
        3'd0: cond_true = 1'b0;
        3'd1: cond_true = s ^ v;
        3'd2: cond_true = z | (s ^ v);
        3'd3: cond_true = c | z;
        3'd4: cond_true = v;
        3'd5: cond_true = s;
        3'd6: cond_true = z;
        3'd7: cond_true = c;
        default: cond_true = 1'b0;
      endcase
      cond_true = cond_true ^ cc[3];
    end
  endfunction
  function [7:0] rd_byte;
    input [7:0] a;
    begin
      case (a)
        `CPUIBX_ADDR_FLAGS: rd_byte = flags_reg;
        `CPUIBX_ADDR_SP: rd_byte = sp_reg;
        `CPUIBX_ADDR_IP_HI: rd_byte = ip_reg[15:8];
        `CPUIBX_ADDR_IP_LO: rd_byte = ip_reg[7:0];
        `CPUIBX_ADDR_SYM: rd_byte = sym_reg;
        default: rd_byte = mem[a];
      endcase
    end
  endfunction
  // ----------------------------------------------------------------
  // combinational operand path
  // ----------------------------------------------------------------
  wire [1:0] len_now = (idx_reg == 2'd0) ? op_len(prog_data) : op_len(op_reg);
  wire fast_now = flags_reg[`CPUIBX_FL_FIS];
  wire [3:0] last_cyc = op_cycles(op_reg, (step_reg == 4'h0) ? fast_now : ea_reg[0]) - 4'd1;
  assign prog_addr = pc_reg + {14'h0000, idx_reg};
  reg [7:0] inc_ea;
  reg [7:0] inc_old;
  reg [7:0] word_ea;
  reg [15:0] word_old;
  always @* begin
    if (op_reg[3:0] == `CPUIBX_NIB_INC) begin
      inc_ea = {`CPUIBX_WREG_BASE, op_reg[7:4]};
    end else if (op_reg == `CPUIBX_OP_INC_IR) begin
      inc_ea = rd_byte(b2_reg);
    end else begin
      inc_ea = b2_reg;
    end
    inc_old = rd_byte(inc_ea);
    if (op_reg == `CPUIBX_OP_WORD_ADD_ONE_OP_IR) begin
      word_ea = rd_byte(b2_reg) & 8'hFE;
    end else begin
      word_ea = {b2_reg[7:1], 1'b0};
    end
    word_old = {rd_byte(word_ea), rd_byte(word_ea | 8'h01)};
  end
  wire [7:0] inc_res = inc_old + 8'h01;
  wire [15:0] word_res = word_old + 16'h0001;
  wire [7:0] stk0 = rd_byte(sp_reg);
  wire [7:0] stk1 = rd_byte(sp_reg + 8'h01);
  wire [7:0] stk2 = rd_byte(sp_reg + 8'h02);
  wire [15:0] pair_val = {rd_byte({b2_reg[7:1], 1'b0}), rd_byte({b2_reg[7:1], 1'b1})};
  wire [15:0] rel_target = pc_reg + {{8{b2_reg[7]}}, b2_reg};
  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  task store;
    input [7:0] a;
    input [7:0] d;
    begin
      case (a)
        `CPUIBX_ADDR_FLAGS: flags_reg <= d;
        `CPUIBX_ADDR_SP: sp_reg <= d;
        `CPUIBX_ADDR_IP_HI: ip_reg[15:8] <= d;
        `CPUIBX_ADDR_IP_LO: ip_reg[7:0] <= d;
        `CPUIBX_ADDR_SYM: sym_reg <= d;
        default: mem[a] <= d;
      endcase
    end
  endtask
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    irq_ack <= 1'b0;
    if (rst) begin
      state_reg <= ST_FETCH;
      pc_reg <= `CPUIBX_RST_PC;
      ip_reg <= `CPUIBX_RST_IP;
      sp_reg <= `CPUIBX_RST_SP;
      flags_reg <= `CPUIBX_RST_FLAGS;
      flags_save_reg <= `CPUIBX_RST_FLAGS;
      sym_reg <= `CPUIBX_RST_SYM;
      op_reg <= 8'h00;
      b2_reg <= 8'h00;
      b3_reg <= 8'h00;
      idx_reg <= 2'd0;
      cyc_reg <= 4'h0;
      step_reg <= 4'h0;
      ea_reg <= 8'h00;
      word_res_reg <= 16'h0000;
      cpu_idle <= 1'b0;
      reg_rdata <= 8'h00;
      pc_value <= `CPUIBX_RST_PC;
    end else begin
      case (state_reg)
        ST_FETCH: begin
          if (idx_reg == 2'd0 && sym_reg[`CPUIBX_SYM_GIE] && irq_req) begin
            state_reg <= ST_INT;
            step_reg <= 4'h0;
          end else begin
            case (idx_reg)
              2'd0: op_reg <= prog_data;
              2'd1: b2_reg <= prog_data;
              default: b3_reg <= prog_data;
            endcase
            cyc_reg <= (idx_reg == 2'd0) ? 4'h1 : cyc_reg + 4'h1;
            if (idx_reg == len_now - 2'd1) begin
              pc_reg <= pc_reg + {14'h0000, len_now};
              idx_reg <= 2'd0;
              step_reg <= 4'h0;
              state_reg <= ST_EXEC;
            end else begin
              idx_reg <= idx_reg + 2'd1;
            end
          end
        end
        ST_EXEC: begin
          cyc_reg <= cyc_reg + 4'h1;
          step_reg <= step_reg + 4'h1;
          if (step_reg == 4'h0) begin
            if (op_reg[3:0] == `CPUIBX_NIB_INC || op_reg == `CPUIBX_OP_INC_R ||
                op_reg == `CPUIBX_OP_INC_IR) begin
              store(inc_ea, inc_res);
              flags_reg[`CPUIBX_FL_Z] <= (inc_res == 8'h00);
              flags_reg[`CPUIBX_FL_S] <= inc_res[7];
              flags_reg[`CPUIBX_FL_V] <= (inc_old == 8'h7F);
            end else if (op_reg == `CPUIBX_OP_WORD_ADD_ONE_OP_RR || op_reg == `CPUIBX_OP_WORD_ADD_ONE_OP_IR) begin
              ea_reg <= word_ea;
              word_res_reg <= word_res;
              store(word_ea | 8'h01, word_res[7:0]);
              flags_reg[`CPUIBX_FL_Z] <= (word_res == 16'h0000);
              flags_reg[`CPUIBX_FL_S] <= word_res[15];
              flags_reg[`CPUIBX_FL_V] <= (word_old == 16'h7FFF);
            end else if (op_reg == `CPUIBX_OP_SERVICE_RETURN_OP) begin
              sym_reg[`CPUIBX_SYM_GIE] <= 1'b1;
              ea_reg <= {7'h00, fast_now};
              if (fast_now) begin
                pc_reg <= ip_reg;
                ip_reg <= pc_reg;
                flags_reg <= {flags_save_reg[7:2], 1'b0, flags_save_reg[0]};
              end else begin
                flags_reg <= stk0;
                pc_reg <= {stk1, stk2};
                sp_reg <= sp_reg + 8'h03;
              end
            end else if (op_reg[3:0] == `CPUIBX_NIB_JP) begin
              if (cond_true(op_reg[7:4], flags_reg)) begin
                pc_reg <= {b2_reg, b3_reg};
              end
            end else if (op_reg == `CPUIBX_OP_JP_IRR) begin
              pc_reg <= pair_val;
            end else if (op_reg[3:0] == `CPUIBX_NIB_JR) begin
              if (cond_true(op_reg[7:4], flags_reg)) begin
                pc_reg <= rel_target;
              end
            end
          end else if (step_reg == 4'h1 &&
                       (op_reg == `CPUIBX_OP_WORD_ADD_ONE_OP_RR || op_reg == `CPUIBX_OP_WORD_ADD_ONE_OP_IR)) begin
            store(ea_reg, word_res_reg[15:8]);
          end
          if (cyc_reg == last_cyc) begin
            if (op_reg == `CPUIBX_OP_IDLE) begin
              state_reg <= ST_HALT;
              cpu_idle <= 1'b1;
            end else begin
              state_reg <= ST_FETCH;
            end
          end
        end
        ST_HALT: begin
          if (irq_req) begin
            state_reg <= ST_FETCH;
            cpu_idle <= 1'b0;
          end
        end
        ST_INT: begin
          step_reg <= step_reg + 4'h1;
          if (irq_fast) begin
            pc_reg <= ip_reg;
            ip_reg <= pc_reg;
            flags_save_reg <= flags_reg;
            flags_reg[`CPUIBX_FL_FIS] <= 1'b1;
            sym_reg[`CPUIBX_SYM_GIE] <= 1'b0;
            irq_ack <= 1'b1;
            state_reg <= ST_FETCH;
          end else begin
            case (step_reg)
              4'h0: store(sp_reg - 8'h01, pc_reg[7:0]);
              4'h1: store(sp_reg - 8'h02, pc_reg[15:8]);
              default: begin
                store(sp_reg - 8'h03, flags_reg);
                sp_reg <= sp_reg - 8'h03;
                pc_reg <= irq_vector;
                sym_reg[`CPUIBX_SYM_GIE] <= 1'b0;
                irq_ack <= 1'b1;
                state_reg <= ST_FETCH;
              end
            endcase
          end
        end
        default: state_reg <= ST_FETCH;
      endcase
      if (reg_wr) begin
        store(reg_addr, reg_wdata);
      end
      reg_rdata <= reg_rd ? rd_byte(reg_addr) : 8'h00;
      pc_value <= pc_reg;
    end
  end
endmodule

// file: dv/cpuibx_core_asserts.sv
// port-level checks on the execution core
module cpuibx_core_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // watched ports
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_req,
  input wire logic irq_fast,
  input wire logic [15:0] irq_vector,
  input wire logic irq_ack,
  input wire logic cpu_idle,
  input wire logic [15:0] pc_value
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ------------------------------
  // sequences
  // ------------------------------
  sequence s_halted;
    cpu_idle && !irq_req;
  endsequence
  sequence s_wake;
    cpu_idle && irq_req;
  endsequence
  sequence s_normal_ack;
    irq_ack && !irq_fast;
  endsequence
  // ------------------------------
  // assertions
  // ------------------------------
  a_rdata_slot_only: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_idle_wakes: assert property (s_wake |=> !cpu_idle)
    else $error("halt not left on request");
  a_idle_pc_still: assert property (s_halted |=> $stable(pc_value))
    else $error("pc moved while halted");
  a_idle_no_ack: assert property (cpu_idle |-> !irq_ack)
    else $error("ack while halted");
  a_ack_one_pulse: assert property (irq_ack |=> !irq_ack)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (irq_ack |-> $past(irq_req))
    else $error("ack without request");
  a_vector_taken: assert property (s_normal_ack |-> ##[0:3] (pc_value[15:4] == irq_vector[15:4]))
    else $error("service address not reached");
  a_reset_start: assert property ($fell(rst) |-> pc_value == 16'h0000 && !cpu_idle)
    else $error("reset did not restart at zero");
endmodule

// file: dv/cpuibx_core_tb.sv
// self-checking bench for the execution core
`include "cpuibx_consts.vh"
module cpuibx_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // signals and design
  // ------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic irq_req = 1'b0;
  logic irq_fast = 1'b0;
  logic [15:0] irq_vector = 16'h0300;
  logic [7:0] mem [0:65535];
  wire [7:0] reg_rdata;
  wire [15:0] prog_addr;
  wire [7:0] prog_data;
  wire irq_ack;
  wire cpu_idle;
  wire [15:0] pc_value;
  int failures = 0;
  int checks_done = 0;
  assign prog_data = mem[prog_addr];
  always #5 sys_clk = ~sys_clk;
  cpuibx_core cpuibx_core_i (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_addr(prog_addr),
    .prog_data(prog_data), .irq_req(irq_req), .irq_fast(irq_fast),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .cpu_idle(cpu_idle), .pc_value(pc_value)
  );
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic boot();
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hFF;
    end
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  task automatic ld(input logic [15:0] a, input logic [23:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      mem[a + i] = b[8 * (n - 1 - i) +: 8];
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    check(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task automatic wait_ack();
    repeat (60) begin
      @(posedge sys_clk);
      if (irq_ack === 1'b1) break;
    end
    check("ack", 16'h0001, {15'h0000, irq_ack});
    irq_req <= 1'b0;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_inc();
    boot();
    ld(16'h0004, 24'h201021, 3);
    ld(16'h0007, 24'h00113E, 2);
    wr(`CPUIBX_ADDR_FLAGS, 8'h80);
    wr(8'h10, 8'hFF);
    wr(8'h11, 8'h50);
    wr(8'h50, 8'hFF);
    wr(8'hC3, 8'h7F);
    repeat (20) @(posedge sys_clk);
    rd("reg 10", 8'h10, 8'h00);
    rd("reg 50", 8'h50, 8'h00);
    rd("reg C3", 8'hC3, 8'h80);
    rd("flags", `CPUIBX_ADDR_FLAGS, 8'hB0);
  endtask
  task automatic t_word_add_one_op();
    boot();
    ld(16'h0004, 24'hA020A1, 3);
    ld(16'h0007, 24'h000012, 1);
    wr(`CPUIBX_ADDR_FLAGS, 8'h80);
    wr(8'h20, 8'h7F);
    wr(8'h21, 8'hFF);
    wr(8'h12, 8'h30);
    wr(8'h30, 8'hFF);
    wr(8'h31, 8'hFF);
    repeat (24) @(posedge sys_clk);
    rd("word hi", 8'h20, 8'h80);
    rd("word lo", 8'h21, 8'h00);
    rd("ind hi", 8'h30, 8'h00);
    rd("ind lo", 8'h31, 8'h00);
    rd("flags", `CPUIBX_ADDR_FLAGS, 8'hC0);
  endtask
  task automatic t_branch();
    boot();
    ld(16'h0004, 24'h7D1234, 3);
    ld(16'h1234, 24'hFD0000, 3);
    ld(16'h1237, 24'h003014, 2);
    ld(16'h2000, 24'h008B7F, 2);
    ld(16'h2081, 24'h008B80, 2);
    ld(16'h2003, 24'h00006F, 1);
    wr(`CPUIBX_ADDR_FLAGS, 8'h80);
    wr(8'h14, 8'h20);
    wr(8'h15, 8'h00);
    repeat (60) @(posedge sys_clk);
    check("idle", 16'h0001, {15'h0000, cpu_idle});
    check("pc halted", 16'h2004, pc_value);
    rd("flags", `CPUIBX_ADDR_FLAGS, 8'h80);
    irq_req <= 1'b1;
    @(posedge sys_clk);
    irq_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("idle left", 16'h0000, {15'h0000, cpu_idle});
    repeat (8) @(posedge sys_clk);
    check("pc resumed", 16'h0001, {15'h0000, pc_value > 16'h2004});
  endtask
  task automatic t_irq();
    boot();
    ld(16'h0303, 24'h0000BF, 1);
    wr(`CPUIBX_ADDR_FLAGS, 8'h80);
    wr(`CPUIBX_ADDR_SYM, 8'h01);
    irq_fast <= 1'b0;
    irq_req <= 1'b1;
    wait_ack();
    rd("stack top", `CPUIBX_ADDR_SP, 8'hBD);
    rd("stacked flags", 8'hBD, 8'h80);
    rd("mode entry", `CPUIBX_ADDR_SYM, 8'h00);
    wr(`CPUIBX_ADDR_FLAGS, 8'h00);
    repeat (24) @(posedge sys_clk);
    rd("flags back", `CPUIBX_ADDR_FLAGS, 8'h80);
    rd("stack back", `CPUIBX_ADDR_SP, 8'hC0);
    rd("mode back", `CPUIBX_ADDR_SYM, 8'h01);
    check("pc back", 16'h0001, {15'h0000, pc_value < 16'h0300});
  endtask
  task automatic t_fast();
    boot();
    ld(16'h0403, 24'h0000BF, 1);
    wr(`CPUIBX_ADDR_FLAGS, 8'h80);
    wr(`CPUIBX_ADDR_IP_HI, 8'h04);
    wr(`CPUIBX_ADDR_IP_LO, 8'h00);
    wr(`CPUIBX_ADDR_SYM, 8'h01);
    irq_fast <= 1'b1;
    irq_req <= 1'b1;
    wait_ack();
    rd("fast flags", `CPUIBX_ADDR_FLAGS, 8'h82);
    rd("fast mode", `CPUIBX_ADDR_SYM, 8'h00);
    check("fast pc", 16'h0004, {8'h00, pc_value[15:8]});
    repeat (16) @(posedge sys_clk);
    check("fast return time", 16'h0003, pc_value);
    rd("fast flags back", `CPUIBX_ADDR_FLAGS, 8'h80);
    rd("fast stack", `CPUIBX_ADDR_SP, 8'hC0);
    rd("fast mode back", `CPUIBX_ADDR_SYM, 8'h01);
    rd("pointer hi", `CPUIBX_ADDR_IP_HI, 8'h04);
    rd("pointer lo", `CPUIBX_ADDR_IP_LO, 8'h04);
    check("pc home", 16'h0001, {15'h0000, pc_value < 16'h0400});
  endtask
  // ------------------------------
  // run and watchdog
  // ------------------------------
  initial begin
    t_inc();
    t_word_add_one_op();
    t_branch();
    t_irq();
    t_fast();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    test_done();
  end
endmodule
bind cpuibx_core cpuibx_core_asserts cpuibx_core_asserts_i (
  .sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_req(irq_req), .irq_fast(irq_fast), .irq_vector(irq_vector),
  .irq_ack(irq_ack), .cpu_idle(cpu_idle), .pc_value(pc_value)
);
